/* fan_slew_map.vh */
// register map, reset values and timing counts of the fan duty slew block
// assumes a 25 MHz clock and a 32-bit APB master
`ifndef FAN_SLEW_MAP_VH
`define FAN_SLEW_MAP_VH

// register byte offsets
`define OFF_CTRL        12'h000
`define OFF_TARGET      12'h004
`define OFF_RATE        12'h008
`define OFF_LIMIT       12'h00C
`define OFF_STATUS      12'h010

// control fields
`define CTRL_CONV_BIT   0
`define CTRL_AUTO_BIT   1
`define CTRL_INV_BIT    2
`define CTRL_NOSPIN_BIT 3

// reset values
`define CTRL_RST        4'h1
`define TARGET_RST      8'h00
`define RATE_RST        4'h0
`define REMOTE_LIM_RST  8'h6E
`define LOCAL_LIM_RST   8'h50

// duty scale
`define DUTY_FULL       8'hF0
`define DUTY_STEP       8'h02

// timing
`define CLK_HZ          25000000
`define SPINUP_MS       2000
`define RATE_BASE_US    1000

`endif

/* fan_pwm_slew.v */
// fan duty slew limiter, power-up defaults and open-drain pwm pin
// assumes an APB master on clk and a pull-up on the fan pwm wire
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
`include "fan_slew_map.vh"

// What this block does
// - when target differs while running, duty moves gradually at the programmed rate.
// - duty stops at target rounded down to even and never steps past it.
// - reset loads remote alarm limit 110 and local limit 80.
// - reset starts conversions, manual mode, duty zero, inversion cleared.
// - after reset the fan pwm pin stays high.
// - duty 240 is full; larger programmed values clamp to 240.
// - starting from standstill with spin-up enabled, pin forced high for 2 s.
// - with spin-up disabled, duty jumps from zero straight to target.
module fan_pwm_slew #(
   parameter SPINUP_CYCLES = (`CLK_HZ / 1000) * `SPINUP_MS,
   parameter RATE_UNIT     = (`CLK_HZ / 1000000) * `RATE_BASE_US
) (
   // clock and reset
   input  wire        clk,
   input  wire        resetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // fan pwm pin, open drain: only ever pulls low
   input  wire        fan_pwm_pin_in,
   output reg         fan_pwm_pin_out,
   output reg         fan_pwm_pin_oe,
   // state seen by neighbouring logic
   output reg         conv_enable,
   output reg         auto_mode,
   output reg  [7:0]  remote_limit,
   output reg  [7:0]  local_limit,
   output reg  [7:0]  duty_now
);

   localparam ST_IDLE = 2'b00;
   localparam ST_SPIN = 2'b01;
   localparam ST_RUN  = 2'b10;

   reg [3:0]  ctrl_reg;
   reg [7:0]  target_reg;
   reg [3:0]  rate_reg;
   reg [1:0]  state_reg;
   reg [26:0] spin_cnt_reg;
   reg [23:0] rate_cnt_reg;
   reg [7:0]  pwm_cnt_reg;
   reg [7:0]  duty_next;
   reg [31:0] rd_next;
   reg        sel_ok;
   reg        pin_seen_reg;

   wire       wr_en   = psel & penable & pwrite;
   wire       no_spin = ctrl_reg[`CTRL_NOSPIN_BIT];
   wire       invert  = ctrl_reg[`CTRL_INV_BIT];
   // interval grows with rate code: code 0 is one unit, code 15 sixteen units
   wire [23:0] rate_len = RATE_UNIT[23:0] * ({20'h0, rate_reg} + 24'h000001);
   wire       rate_tick = (rate_cnt_reg >= rate_len - 24'h000001);

   // clamped and evened target
   wire [7:0] tgt_clamp = (target_reg > `DUTY_FULL) ? `DUTY_FULL : target_reg;
   wire [7:0] tgt_even  = {tgt_clamp[7:1], 1'b0};

   // apb decode
   always @* begin
      sel_ok  = 1'b1;
      rd_next = 32'h00000000;
      case (paddr)
         `OFF_CTRL:   rd_next = {28'h0, ctrl_reg};
         `OFF_TARGET: rd_next = {24'h0, target_reg};
         `OFF_RATE:   rd_next = {28'h0, rate_reg};
         `OFF_LIMIT:  rd_next = {16'h0, local_limit, remote_limit};
         `OFF_STATUS: rd_next = {21'h0, pin_seen_reg, state_reg, duty_now};
         default:     sel_ok  = 1'b0;
      endcase
   end

   // zero-wait-state slave: pready rises in the first access cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~sel_ok;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_next : 32'h00000000;
      end
   end

   // registers; power-up defaults
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg     <= `CTRL_RST;
         target_reg   <= `TARGET_RST;
         rate_reg     <= `RATE_RST;
         remote_limit <= `REMOTE_LIM_RST;
         local_limit  <= `LOCAL_LIM_RST;
      end else if (wr_en && pready && sel_ok) begin
         case (paddr)
            `OFF_CTRL:   ctrl_reg   <= pwdata[3:0];
            `OFF_TARGET: target_reg <= pwdata[7:0];
            `OFF_RATE:   rate_reg   <= pwdata[3:0];
            `OFF_LIMIT: begin
               remote_limit <= pwdata[7:0];
               local_limit  <= pwdata[15:8];
            end
            default: ;
         endcase
      end
   end

   // next duty value
   always @* begin
      duty_next = duty_now;
      if (duty_now < tgt_even)
         duty_next = duty_now + `DUTY_STEP;
      else if (duty_now > tgt_even)
         duty_next = duty_now - `DUTY_STEP;
   end

   // free-running interval counter; the >= compare lets a shorter interval take hold at once
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rate_cnt_reg <= 24'h000000;
      end else if (rate_tick) begin
         rate_cnt_reg <= 24'h000000;
      end else begin
         rate_cnt_reg <= rate_cnt_reg + 24'h000001;
      end
   end

   // slew state machine
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg    <= ST_IDLE;
         duty_now     <= 8'h00;
         spin_cnt_reg <= 27'h0000000;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               duty_now <= 8'h00;
               if (tgt_even != 8'h00) begin
                  if (no_spin) begin
                     duty_now  <= tgt_even;
                     state_reg <= ST_RUN;
                  end else begin
                     spin_cnt_reg <= 27'h0000000;
                     state_reg    <= ST_SPIN;
                  end
               end
            end
            ST_SPIN: begin
               if (spin_cnt_reg == SPINUP_CYCLES[26:0] - 27'h0000001) begin
                  duty_now  <= tgt_even;
                  state_reg <= ST_RUN;
               end else begin
                  spin_cnt_reg <= spin_cnt_reg + 27'h0000001;
               end
            end
            ST_RUN: begin
               // steps of two keep the value even and never overshoot an even target
               if (rate_tick)
                  duty_now <= duty_next;
               if (duty_now == 8'h00 && tgt_even == 8'h00)
                  state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // pwm period of 240 clocks
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwm_cnt_reg <= 8'h00;
      end else if (pwm_cnt_reg == `DUTY_FULL - 8'h01) begin
         pwm_cnt_reg <= 8'h00;
      end else begin
         pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      end
   end

   // registered copies of the control bits for the conversion and fan-law logic
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conv_enable <= 1'b1;
         auto_mode   <= 1'b0;
      end else begin
         conv_enable <= ctrl_reg[`CTRL_CONV_BIT];
         auto_mode   <= ctrl_reg[`CTRL_AUTO_BIT];
      end
   end

   // wire level as the pin sees it, read back in the status word
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_seen_reg <= 1'b1;
      end else begin
         pin_seen_reg <= fan_pwm_pin_in;
      end
   end

   // open drain: oe high pulls the wire low, oe low leaves it to the pull-up.
   // with invert clear the active phase pulls low, so duty zero keeps the pin high
   // and a fan behind a low-side transistor runs at full speed until software acts
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fan_pwm_pin_out <= 1'b0;
         fan_pwm_pin_oe  <= 1'b0;
      end else begin
         fan_pwm_pin_out <= 1'b0;
         if (state_reg == ST_SPIN)
            fan_pwm_pin_oe <= 1'b0;
         else
            fan_pwm_pin_oe <= (pwm_cnt_reg < duty_now) ^ invert;
      end
   end

endmodule

/* fan_model.sv */
// fan drive model: pull-up on the pwm wire, counts cycles the wire sits high
// assumes oe high means the block pulls the wire low
`timescale 1ns/10ps
module fan_model (
   // clock
   input  wire    clk,
   // pwm wire
   input  wire    oe,
   output wire    pin,
   output integer high_len
);
   assign pin = oe ? 1'b0 : 1'b1;
   initial high_len = 0;
   always @(posedge clk) high_len <= pin ? high_len + 1 : 0;
endmodule

/* fan_pwm_slew_asserts.sv */
// checker on the duty slew block ports
// assumes the bench's short rate unit, so duty steps are two clocks apart at least
`timescale 1ns/10ps
module fan_pwm_slew_asserts (
   // clock and reset
   input wire       clk,
   input wire       resetn,
   // pin and state
   input wire       fan_pwm_pin_out,
   input wire       fan_pwm_pin_oe,
   input wire       conv_enable,
   input wire       auto_mode,
   input wire [7:0] remote_limit,
   input wire [7:0] local_limit,
   input wire [7:0] duty_now
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_even; duty_now[0] == 1'b0; endproperty
   a_even: assert property (p_even) else $error("odd duty");
   property p_max; duty_now <= 8'hF0; endproperty
   a_max: assert property (p_max) else $error("duty above full");
   property p_step; $changed(duty_now) && $past(duty_now) != 0 && duty_now != 0
      |-> duty_now - $past(duty_now) == 8'h02 || $past(duty_now) - duty_now == 8'h02; endproperty
   a_step: assert property (p_step) else $error("duty step not two");
   property p_pace; $changed(duty_now) |=> $stable(duty_now); endproperty
   a_pace: assert property (p_pace) else $error("duty moved twice in a row");
   // no disable here: the pin must be released while reset is held
   property p_rst_pin; disable iff (1'b0) !resetn |-> !fan_pwm_pin_oe; endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("pin pulled in reset");
   property p_od; fan_pwm_pin_out == 1'b0; endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   property p_lim; $rose(resetn) |-> remote_limit == 8'h6E && local_limit == 8'h50; endproperty
   a_lim: assert property (p_lim) else $error("alarm limits wrong");
   property p_def; $rose(resetn) |-> conv_enable && !auto_mode && duty_now == 8'h00; endproperty
   a_def: assert property (p_def) else $error("power-up state wrong");
   c_full: cover property (duty_now == 8'hF0);
   c_pin: cover property ($rose(fan_pwm_pin_oe));
   c_slew: cover property ($changed(duty_now) && $past(duty_now) != 0);
endmodule
bind fan_pwm_slew fan_pwm_slew_asserts chk (.clk(clk), .resetn(resetn),
   .fan_pwm_pin_out(fan_pwm_pin_out), .fan_pwm_pin_oe(fan_pwm_pin_oe),
   .conv_enable(conv_enable), .auto_mode(auto_mode), .remote_limit(remote_limit),
   .local_limit(local_limit), .duty_now(duty_now));

/* testbench.sv */
// bench: apb tasks and directed checks of the duty slew block
// assumes the short spin-up and rate counts set below
`timescale 1ns/10ps
module testbench;
   reg         clk = 0, resetn = 1, psel = 0, penable = 0, pwrite = 0, er;
   reg  [11:0] paddr = 0;
   reg  [31:0] pwdata = 0, rd;
   wire [31:0] prdata;
   wire        pready, pslverr, pin, pout, oe, conv, auto;
   wire [7:0]  rlim, llim, duty;
   integer     bad_count = 0, compares = 0, n;
   wire [31:0] high_len;
   initial forever #20 clk = ~clk;
   fan_pwm_slew #(.SPINUP_CYCLES(100), .RATE_UNIT(2)) dut (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fan_pwm_pin_in(pin),
      .fan_pwm_pin_out(pout), .fan_pwm_pin_oe(oe), .conv_enable(conv), .auto_mode(auto),
      .remote_limit(rlim), .local_limit(llim), .duty_now(duty));
   fan_model fan (.clk(clk), .oe(oe), .pin(pin), .high_len(high_len));
   task conclude;
      begin
         $display("compares %0d bad_count %0d", compares, bad_count);
         if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one idle cycle between transfers keeps every strobe to one change per step
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
         @(posedge clk) penable <= 1;
         n = 0;
         do begin @(posedge clk); n = n + 1; end while (pready !== 1'b1 && n < 20);
         if (n >= 20) begin bad_count = bad_count + 1; conclude; end
         rd = prdata; er = pslverr;
         psel <= 0; penable <= 0;
      end
   endtask
   task wait_duty(input [7:0] v);
      begin
         n = 0;
         while (duty !== v && n < 1000) begin @(posedge clk); n = n + 1; end
         cmp(duty, v);
         if (n >= 1000) conclude;
      end
   endtask
   // power-up state, checked after every release of reset
   task check_defaults;
      begin
         @(posedge clk);
         cmp({conv, auto, duty}, 10'h200);
         cmp({llim, rlim}, 16'h506E);
         apb(0, 12'h00C, 0);
         cmp(rd, 32'h506E);
         apb(0, 12'h000, 0);
         cmp(rd, 32'h1);
         apb(0, 12'h010, 0);
         cmp(rd, 32'h400);
         repeat (4) @(posedge clk);
         cmp(pin, 1);
         cmp(high_len >= 10, 1);
      end
   endtask
   initial begin
      resetn <= 0;
      repeat (16) @(posedge clk);
      cmp(pin, 1);
      resetn <= 1;
      check_defaults;
      apb(0, 12'h014, 0);
      cmp(er, 1);
      cmp(rd, 0);
      apb(1, 12'h000, 32'h9);
      apb(1, 12'h004, 32'hFF);
      repeat (2) @(posedge clk);
      cmp(duty, 8'hF0);
      @(posedge clk);
      cmp(pin, 0);
      apb(1, 12'h004, 32'h31);
      wait_duty(8'h30);
      repeat (20) @(posedge clk);
      cmp(duty, 8'h30);
      n = 0;
      repeat (240) begin
         @(posedge clk);
         if (pin === 1'b0) n = n + 1;
      end
      cmp(n, 48);
      apb(1, 12'h008, 32'h3);
      apb(1, 12'h004, 32'h40);
      wait_duty(8'h32);
      n = 0;
      while (duty === 8'h32 && n < 50) begin @(posedge clk); n = n + 1; end
      cmp(n, 8);
      apb(1, 12'h004, 0);
      wait_duty(8'h00);
      // invert set so the idle pin sits low and the spin-up pulse stands out
      apb(1, 12'h000, 32'h5);
      apb(1, 12'h004, 32'h10);
      wait_duty(8'h10);
      cmp(high_len >= 98 && high_len <= 102, 1);
      apb(1, 12'h00C, 32'h1234);
      apb(0, 12'h00C, 0);
      cmp(rd, 32'h1234);
      resetn <= 0;
      repeat (2) @(posedge clk);
      cmp(pin, 1);
      resetn <= 1;
      check_defaults;
      conclude;
   end
endmodule
